/* include/oac_cfg.svh */
// oac_cfg.svh: timing counts for the amplitude-mode clock hold
// assumes a single core clock; included by bare name
`ifndef OAC_CFG_SVH
`define OAC_CFG_SVH

`define OAC_CLK_PERIOD_NS 40
// hold window after amplitude-mode set or stop release, in ns
`define OAC_HOLD_MIN_NS 4060
`define OAC_HOLD_MAX_NS 16120
// least time rounds up to whole cycles
`define OAC_HOLD_MIN_CYC ((`OAC_HOLD_MIN_NS + `OAC_CLK_PERIOD_NS - 1) / `OAC_CLK_PERIOD_NS)
// longest time rounds down
`define OAC_HOLD_MAX_CYC (`OAC_HOLD_MAX_NS / `OAC_CLK_PERIOD_NS)
// hold counted in external clock periods
`define OAC_EXT_HOLD_TICKS 160
// crystal stabilization default, in core cycles
`define OAC_OSC_STAB_CYC 8192
// counter width default
`define OAC_CNT_W 14
// reset value of the amplitude-mode bit
`define OAC_AMP_RST 1'b0

`endif

/* include/oac_pkg.sv */
// oac_pkg: types shared by the amplitude-mode clock hold modules
// assumes nothing beyond a SystemVerilog compiler
package oac_pkg;

    // cpu clock source as reported by the clock selector
    typedef enum logic [1:0] {
        OAC_SRC_XTAL,
        OAC_SRC_EXTCLK,
        OAC_SRC_HSOSC
    } oac_clk_src_type;

    // cpu clock gate controller states
    typedef enum logic {
        OAC_ST_RUN,
        OAC_ST_HOLD
    } oac_state_type;

endpackage : oac_pkg

/* include/oac_tmr_if.sv */
// oac_tmr_if: hold controller to hold timer connection
// assumes both ends share one clock
`timescale 1ns/100ps
interface oac_tmr_if #(
    parameter int CNT_W = 14
);
    logic start;
    logic ext_mode;
    logic [CNT_W-1:0] limit;
    logic ext_tick;
    logic done;
    logic busy;

    modport ctl (output start, output ext_mode, output limit, output ext_tick,
                 input done, input busy);
    modport tmr (input start, input ext_mode, input limit, input ext_tick,
                 output done, output busy);
endinterface : oac_tmr_if

/* verilog/oac_hold_timer.sv */
// oac_hold_timer: counts a hold interval in core cycles or external ticks
// assumes start is a one-cycle pulse and limit is at least one
`timescale 1ns/100ps
module oac_hold_timer #(
    parameter int CNT_W = 14
) (
    input wire logic i_core_clk,
    input wire logic i_arst_n,
    oac_tmr_if.tmr tif
);
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic [CNT_W-1:0] limit_r;
    logic ext_mode_r;
    logic busy_r;
    logic done_r;
    logic step;

    assign step = ext_mode_r ? tif.ext_tick : 1'b1;
    assign cnt_nxt = cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cnt_r <= '0;
            limit_r <= '0;
            ext_mode_r <= 1'b0;
            busy_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            done_r <= 1'b0;
            if (tif.start) begin
                cnt_r <= '0;
                limit_r <= tif.limit;
                ext_mode_r <= tif.ext_mode;
                busy_r <= 1'b1;
            end else if (busy_r && step) begin
                cnt_r <= cnt_nxt;
                if (cnt_nxt == limit_r) begin
                    busy_r <= 1'b0;
                    done_r <= 1'b1;
                end
            end
        end
    end

    assign tif.done = done_r;
    assign tif.busy = busy_r;
endmodule : oac_hold_timer

/* verilog/oac_clock_hold.sv */
// oac_clock_hold: amplitude-mode bit with cpu clock hold-off
// assumes all inputs synchronous to i_core_clk, ext tick one cycle per
// external clock period, stop release a one-cycle pulse
`timescale 1ns/100ps
`include "oac_cfg.svh"
module oac_clock_hold #(
    parameter int CNT_W = `OAC_CNT_W,
    parameter int OSC_STAB_CYC = `OAC_OSC_STAB_CYC
) (
    input wire logic i_core_clk,
    input wire logic i_arst_n,
    input wire logic i_amp_wr,
    input wire logic i_amp_wdata,
    input wire logic [1:0] i_clk_src,
    input wire logic i_ext_clk_tick,
    input wire logic i_stop_release,
    output logic o_osc_amplitude_mode_bit,
    output logic o_amp_locked,
    output logic o_cpu_clk_en,
    output logic o_hold_active
);
    localparam int HOLD_CYC = `OAC_HOLD_MIN_CYC;
    localparam int HOLD_MAX = `OAC_HOLD_MAX_CYC;
    localparam int EXT_TICKS = `OAC_EXT_HOLD_TICKS;

    // elaboration checks; a bad parameter set never reaches simulation
    if (CNT_W < 2 || CNT_W > 31) begin : g_bad_cnt_w
        $error("oac_clock_hold: CNT_W out of range");
    end
    if (OSC_STAB_CYC < 1 || OSC_STAB_CYC >= (1 << CNT_W)) begin : g_bad_stab
        $error("oac_clock_hold: OSC_STAB_CYC does not fit the counter");
    end
    if (EXT_TICKS >= (1 << CNT_W) || HOLD_CYC >= (1 << CNT_W)) begin : g_bad_hold_w
        $error("oac_clock_hold: hold counts do not fit the counter");
    end
    // gate stays low two cycles beyond the count
    if (HOLD_CYC + 2 > HOLD_MAX) begin : g_bad_hold_len
        $error("oac_clock_hold: hold exceeds its longest time");
    end

    // limit selection is shared by both trigger paths
    function automatic logic [CNT_W:0] sel_hold(input oac_pkg::oac_clk_src_type src,
                                                input logic from_stop);
        logic [CNT_W:0] r;
        r = '0;
        unique case (src)
            oac_pkg::OAC_SRC_XTAL: begin
                if (from_stop)
                    r = {1'b0, CNT_W'(OSC_STAB_CYC)};
                else
                    r = {1'b0, CNT_W'(HOLD_CYC)};
            end
            oac_pkg::OAC_SRC_EXTCLK: begin
                r = {1'b1, CNT_W'(EXT_TICKS)};
            end
            oac_pkg::OAC_SRC_HSOSC: begin
                // no amplitude effect on the running oscillator at set time
                if (from_stop)
                    r = {1'b0, CNT_W'(HOLD_CYC)};
            end
            default: begin
                r = '0;
            end
        endcase
        return r;
    endfunction : sel_hold

    oac_tmr_if #(.CNT_W(CNT_W)) tif ();

    oac_hold_timer #(.CNT_W(CNT_W)) u_timer (
        .i_core_clk(i_core_clk),
        .i_arst_n(i_arst_n),
        .tif(tif)
    );

    oac_pkg::oac_state_type state_r;
    oac_pkg::oac_clk_src_type src;
    logic amp_r;
    logic locked_r;
    logic cpu_en_r;
    logic hold_r;
    logic start_r;
    logic ext_mode_r;
    logic [CNT_W-1:0] limit_r;
    logic accept;
    logic set_trig;
    logic stop_trig;
    logic [CNT_W:0] hold_sel;
    logic hold_req;

    assign src = oac_pkg::oac_clk_src_type'(i_clk_src);
    assign accept = i_amp_wr && !locked_r;
    assign set_trig = accept && i_amp_wdata && !amp_r;
    assign stop_trig = i_stop_release && amp_r;
    assign hold_sel = sel_hold(src, stop_trig && !set_trig);
    // a zero limit means this source needs no hold
    assign hold_req = (set_trig || stop_trig) && (hold_sel[CNT_W-1:0] != '0);

    // write-once amplitude mode bit; software is trusted to write it early
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            amp_r <= `OAC_AMP_RST;
            locked_r <= 1'b0;
        end else if (accept) begin
            amp_r <= i_amp_wdata;
            locked_r <= 1'b1;
        end
    end

    // gate controller; triggers while holding are absorbed by the hold
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_r <= oac_pkg::OAC_ST_RUN;
            cpu_en_r <= 1'b1;
            start_r <= 1'b0;
            ext_mode_r <= 1'b0;
            limit_r <= '0;
        end else begin
            start_r <= 1'b0;
            unique case (state_r)
                oac_pkg::OAC_ST_RUN: begin
                    if (hold_req) begin
                        state_r <= oac_pkg::OAC_ST_HOLD;
                        cpu_en_r <= 1'b0;
                        start_r <= 1'b1;
                        ext_mode_r <= hold_sel[CNT_W];
                        limit_r <= hold_sel[CNT_W-1:0];
                    end
                end
                oac_pkg::OAC_ST_HOLD: begin
                    if (tif.done && !tif.busy) begin
                        state_r <= oac_pkg::OAC_ST_RUN;
                        cpu_en_r <= 1'b1;
                    end
                end
            endcase
        end
    end

    // hold flag kept in its own flop so the pin is not a decode
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            hold_r <= 1'b0;
        end else if (state_r == oac_pkg::OAC_ST_RUN && hold_req) begin
            hold_r <= 1'b1;
        end else if (state_r == oac_pkg::OAC_ST_HOLD && tif.done && !tif.busy) begin
            hold_r <= 1'b0;
        end
    end

    assign tif.start = start_r;
    assign tif.ext_mode = ext_mode_r;
    assign tif.limit = limit_r;
    assign tif.ext_tick = i_ext_clk_tick;

    assign o_osc_amplitude_mode_bit = amp_r;
    assign o_amp_locked = locked_r;
    assign o_cpu_clk_en = cpu_en_r;
    assign o_hold_active = hold_r;
endmodule : oac_clock_hold

/* verification/oac_clock_hold_props.sv */
// oac_clock_hold_props: port assertions for the amplitude-mode clock hold
// assumes bind onto oac_clock_hold, single core clock domain
`timescale 1ns/100ps
module oac_clock_hold_props #(
    parameter int OSC_STAB_CYC = 20
) (
    input wire logic i_core_clk,
    input wire logic i_arst_n,
    input wire logic i_amp_wr,
    input wire logic i_amp_wdata,
    input wire logic [1:0] i_clk_src,
    input wire logic i_ext_clk_tick,
    input wire logic i_stop_release,
    input wire logic o_osc_amplitude_mode_bit,
    input wire logic o_amp_locked,
    input wire logic o_cpu_clk_en,
    input wire logic o_hold_active
);
    localparam int XS_LOW = OSC_STAB_CYC + 1;
    logic [7:0] tick_cnt_r;
    logic hold_d_r;
    wire set_w = i_amp_wr && !o_amp_locked && i_amp_wdata && !o_hold_active;
    wire stop_w = i_stop_release && o_osc_amplitude_mode_bit && !o_hold_active;
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_arst_n);
    // ticks the timer sees; the edge that starts the timer takes none
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            tick_cnt_r <= 8'h00;
            hold_d_r <= 1'b0;
        end else begin
            hold_d_r <= o_hold_active;
            if (!o_hold_active) begin
                tick_cnt_r <= 8'h00;
            end else if (i_ext_clk_tick && hold_d_r) begin
                tick_cnt_r <= tick_cnt_r + 8'h01;
            end
        end
    end
    a_first_write: assert property (i_amp_wr && !o_amp_locked |=> o_amp_locked
        && o_osc_amplitude_mode_bit == $past(i_amp_wdata)) else $error("first write lost");
    a_later_ignored: assert property (o_amp_locked |=> o_amp_locked
        && $stable(o_osc_amplitude_mode_bit)) else $error("late write taken");
    a_xtal_set: assert property (set_w && i_clk_src == 2'h0 |=> !o_cpu_clk_en
        ##103 !o_cpu_clk_en ##1 o_cpu_clk_en) else $error("crystal set hold");
    a_ext_stays: assert property (o_hold_active && i_clk_src == 2'h1
        && tick_cnt_r < 8'h9F |=> o_hold_active) else $error("ext hold short");
    a_ext_ends: assert property (o_hold_active && tick_cnt_r == 8'hA0
        |-> ##[0:2] !o_hold_active) else $error("ext hold long");
    a_hs_stop: assert property (stop_w && i_clk_src == 2'h2 |=> !o_cpu_clk_en
        ##103 !o_cpu_clk_en ##1 o_cpu_clk_en) else $error("hs stop hold");
    a_xtal_stop: assert property (stop_w && i_clk_src == 2'h0 |=> !o_cpu_clk_en
        ##XS_LOW !o_cpu_clk_en ##1 o_cpu_clk_en) else $error("stab hold");
    a_en_pair: assert property (o_hold_active == !o_cpu_clk_en)
        else $error("enable and hold disagree");
    cover property (set_w && i_clk_src == 2'h1);
    cover property (stop_w && i_clk_src == 2'h0);
    cover property (i_amp_wr && o_amp_locked);
endmodule : oac_clock_hold_props

/* verification/tb.sv */
// tb: self-checking bench for the amplitude-mode clock hold
// assumes rising-edge design; bench drives on the falling edge
`timescale 1ns/100ps
module tb;
    localparam int OSC = 20;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic wr = 1'b0, wd = 1'b0, tick = 1'b0, stp = 1'b0;
    logic [1:0] src = 2'h0;
    logic bit_o, lock_o, en_o, hold_o;
    logic [31:0] rng = 32'h429C;
    int n_mismatch = 0, samples_checked = 0, width = 0;
    int exp_q[$];
    always #20 clk = ~clk;
    oac_clock_hold #(.OSC_STAB_CYC(OSC)) i_dut (.i_core_clk(clk), .i_arst_n(rst_n),
        .i_amp_wr(wr), .i_amp_wdata(wd), .i_clk_src(src), .i_ext_clk_tick(tick),
        .i_stop_release(stp), .o_osc_amplitude_mode_bit(bit_o), .o_amp_locked(lock_o),
        .o_cpu_clk_en(en_o), .o_hold_active(hold_o));
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (e !== g) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
        end
    endtask : chk
    function automatic logic [31:0] xorshift(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        y = y ^ (y << 5);
        return y;
    endfunction : xorshift
    task automatic final_report();
        $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : final_report
    // outputs settle after the rising edge; look at them on the falling one
    always @(negedge clk) begin
        if (en_o === 1'b0) begin
            width++;
            chk("hold flag", 1'b1, hold_o);
        end else if (width > 0) begin
            chk("hold width", (exp_q.size() > 0) ? exp_q.pop_front() : 0, width);
            chk("hold flag", 1'b0, hold_o);
            width = 0;
        end
    end
    task automatic rst();
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
    endtask : rst
    // e = 0 means no hold; external mode works e out from tick edges
    task automatic go(input logic [1:0] s, input logic w, input int e);
        int ed;
        int n;
        @(negedge clk);
        src = s;
        wr = w;
        wd = 1'b1;
        stp = !w;
        @(negedge clk);
        wr = 1'b0;
        stp = 1'b0;
        if (s == 2'h1) begin
            @(negedge clk);
            ed = 2;
            n = 0;
            while (n < 160) begin
                rng = xorshift(rng);
                tick = rng[0];
                n += int'(rng[0]);
                @(negedge clk);
                ed++;
            end
            tick = 1'b0;
            e = ed;
        end
        if (e > 0) exp_q.push_back(e);
        repeat (2) @(negedge clk);
        for (n = 0; n < 2000 && en_o !== 1'b1; n++) @(negedge clk);
        @(negedge clk);
    endtask : go
    initial begin
        #400000;
        n_mismatch++;
        final_report();
    end
    initial begin
        rst();
        go(2'h0, 1'b1, 104);
        chk("locked", 1'b1, lock_o);
        wr = 1'b1;
        wd = 1'b0;
        @(negedge clk);
        wr = 1'b0;
        chk("mode bit", 1'b1, bit_o);
        go(2'h2, 1'b0, 104);
        go(2'h0, 1'b0, OSC + 2);
        go(2'h1, 1'b0, 0);
        rst();
        go(2'h1, 1'b1, 0);
        rst();
        wr = 1'b1;
        wd = 1'b0;
        @(negedge clk);
        wd = 1'b1;
        go(2'h2, 1'b0, 0);
        chk("mode bit", 1'b0, bit_o);
        rst();
        go(2'h2, 1'b1, 0);
        chk("mode bit", 1'b1, bit_o);
        go(2'h3, 1'b0, 0);
        chk("pending holds", 0, exp_q.size());
        final_report();
    end
endmodule : tb
bind oac_clock_hold oac_clock_hold_props #(.OSC_STAB_CYC(OSC_STAB_CYC)) i_props (
    .i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_amp_wr(i_amp_wr),
    .i_amp_wdata(i_amp_wdata), .i_clk_src(i_clk_src), .i_ext_clk_tick(i_ext_clk_tick),
    .i_stop_release(i_stop_release), .o_osc_amplitude_mode_bit(o_osc_amplitude_mode_bit),
    .o_amp_locked(o_amp_locked), .o_cpu_clk_en(o_cpu_clk_en), .o_hold_active(o_hold_active));
